/* File: hw/tsx_pkg.sv */
package tsx_pkg;
    localparam int NSRC   = 11;
    localparam int NCONV  = 9;
    localparam int NDST   = 6;
    localparam int NCH    = 8;
    localparam int TS_W   = 32;
    localparam int RATIO_W = 16;
    localparam int SEL_W  = 5;

    // source numbering on the crosspoint selectors
    localparam logic [4:0] SRC_REF0     = 5'h00;
    localparam logic [4:0] SRC_FB0      = 5'h04;
    localparam logic [4:0] SRC_FB1      = 5'h05;
    localparam logic [4:0] SRC_AUX0     = 5'h06;
    localparam logic [4:0] SRC_PINGPONG = 5'h08;
    localparam logic [4:0] SRC_OSC0     = 5'h09;
    localparam logic [4:0] SRC_NONE     = 5'h1f;
    localparam int NREF_SRC = 4;
    localparam int NTAG_SRC = 6;

    // destination channels on the link
    localparam int D_PLL0  = 0;
    localparam int D_PLL1  = 1;
    localparam int D_COMP  = 2;
    localparam int D_SKEW  = 3;
    localparam int D_USER0 = 4;
    localparam int D_USER1 = 5;
    localparam int CH_FB0  = 6;
    localparam int CH_FB1  = 7;

    // permitted sources per destination, bit n = source n
    localparam logic [NDST-1:0][NSRC-1:0] ROUTE_MASK = {
        11'h7ff, 11'h7ff, 11'h7ff, 11'h0cf, 11'h61f, 11'h62f};

    // register word indices; byte address is four times the index
    localparam logic [13:0] IDX_RATIO0  = 14'h280b;
    localparam logic [13:0] IDX_SHIFT0  = 14'h280d;
    localparam logic [13:0] IDX_RATIO1  = 14'h284b;
    localparam logic [13:0] IDX_SHIFT1  = 14'h284d;
    localparam logic [13:0] IDX_PERIOD  = 14'h2900;
    localparam logic [13:0] IDX_SEL     = 14'h2a00;
    localparam logic [13:0] IDX_CTRL    = 14'h2a10;
    localparam logic [13:0] IDX_TRIM    = 14'h2a11;
    localparam logic [13:0] IDX_TIME    = 14'h2a12;

    localparam int CTRL_COMP_EN   = 0;
    localparam int CTRL_PLL0_TAGS = 1;
    localparam int CTRL_PLL1_TAGS = 2;

    localparam logic [15:0]     RATIO_RST  = 16'h0000;
    localparam logic [15:0]     SHIFT_RST  = 16'h0000;
    localparam logic [TS_W-1:0] PERIOD_RST = 32'h0000_0000;
    localparam logic [4:0]      SEL_RST    = 5'h1f;
    localparam logic [2:0]      CTRL_RST   = 3'h0;
    localparam logic [7:0]      TRIM_RST   = 8'h00;

    // time base counts 1/256 of a system clock cycle per unit
    localparam logic [TS_W-1:0] TB_STEP = 32'h0000_0100;
endpackage

/* File: hw/tsx_link_if.sv */
`timescale 1ns/1ns
interface tsx_link_if;
    import tsx_pkg::*;
    logic [NCH-1:0]           valid;
    logic [NCH-1:0]           tag;
    logic [NCH-1:0]           lowres;
    logic [NCH-1:0][TS_W-1:0] stamp;

    modport src (output valid, output tag, output lowres, output stamp);
    modport dst (input valid, input tag, input lowres, input stamp);
endinterface

/* File: hw/tsx_device.sv */
// Operation
// - one stamp per rising input edge
// - user keeps converter inputs 1 Hz to 200 kHz
// - time base from clock, trimmed when compensation enabled
// - eleven sources; oscillators stamp without converter
// - nominal period programmed per source, used as expectation; the ping pong source has no period register
// - raw stamps never readable by software
// - reference converters reach all six destinations
// - feedback and oscillator routing limits
// - auxiliary and ping pong routing limits
// - stamps may carry a tag marker
// - tag-configured destinations take only tagged stamps
// - oscillator stamps step by exactly one period
// - ratio N tags one in N+1 stamps
// - ratio zero disables oscillator tagging
// - shift field signed, self-clearing after use
// - shift moves tags by K periods; K below N
// - no shift while oscillator feeds running PLL
// - reference tags come from demodulation sync events
// - feedback tags come from modulation sync events
// - each PLL pairs reference and feedback stamps
// - software picks user processor source, 5-bit selector
//
// The APB slave port was decided locally.
`timescale 1ns/1ns
module tsx_device
    import tsx_pkg::*;
(
    input  wire logic          pclk,
    input  wire logic          presetn,
    input  wire logic          psel,
    input  wire logic          penable,
    input  wire logic          pwrite,
    input  wire logic [15:0]   paddr,
    input  wire logic [31:0]   pwdata,
    output logic      [31:0]   prdata_ff,
    output logic               pready_ff,
    output logic               pslverr_ff,
    input  wire logic [8:0]    conv_clk_pin,
    input  wire logic [3:0]    demod_sync_pin,
    input  wire logic [1:0]    mod_sync_pin,
    tsx_link_if.src            link
);
    localparam int NPIN = NCONV + NREF_SRC + 2;

    logic [15:0]     ratio_ff  [2];
    logic [15:0]     shift_ff  [2];
    logic [TS_W-1:0] period_ff [NSRC];
    logic [4:0]      sel_ff    [NDST];
    logic [2:0]      ctrl_ff;
    logic [7:0]      trim_ff;
    logic [TS_W-1:0] tb_ff;
    logic [TS_W-1:0] tb_step;
    logic [NPIN-1:0] s1_ff, s2_ff, s3_ff, rise;
    logic [NTAG_SRC-1:0] tag_pend_ff;
    logic [NSRC-1:0]     src_valid_ff, src_tag_ff, src_low_ff;
    logic [TS_W-1:0]     src_stamp_ff [NSRC];
    logic [1:0]          shift_apply;
    logic [13:0]         idx;
    logic                wr_en, setup;
    logic [31:0]         nxt_rdata;
    logic                nxt_err;

    // ---------------- APB slave, no wait state, ready in first access cycle ----------------
    assign idx   = paddr[15:2];
    assign setup = psel & ~penable;
    assign wr_en = psel & penable & pready_ff & pwrite;

    always_comb begin
        nxt_rdata = 32'h0000_0000;
        nxt_err   = 1'b0;
        if (idx == IDX_RATIO0) begin
            nxt_rdata = {16'h0000, ratio_ff[0]};
        end else if (idx == IDX_SHIFT0) begin
            nxt_rdata = {16'h0000, shift_ff[0]};
        end else if (idx == IDX_RATIO1) begin
            nxt_rdata = {16'h0000, ratio_ff[1]};
        end else if (idx == IDX_SHIFT1) begin
            nxt_rdata = {16'h0000, shift_ff[1]};
        end else if (idx >= IDX_PERIOD && idx < IDX_PERIOD + 14'(NSRC)
                     && idx != IDX_PERIOD + 14'(SRC_PINGPONG)) begin
            nxt_rdata = period_ff[4'(idx - IDX_PERIOD)];
        end else if (idx >= IDX_SEL && idx < IDX_SEL + 14'(NDST)) begin
            nxt_rdata = {27'h0, sel_ff[3'(idx - IDX_SEL)]};
        end else if (idx == IDX_CTRL) begin
            nxt_rdata = {29'h0, ctrl_ff};
        end else if (idx == IDX_TRIM) begin
            nxt_rdata = {24'h0, trim_ff};
        end else if (idx == IDX_TIME) begin
            nxt_rdata = tb_ff;
        end else begin
            // stamp buffers are deliberately absent from the map
            nxt_err = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_ff  <= 1'b0;
            prdata_ff  <= 32'h0000_0000;
            pslverr_ff <= 1'b0;
        end else begin
            pready_ff <= setup;
            if (setup) begin
                prdata_ff  <= pwrite ? 32'h0000_0000 : nxt_rdata;
                pslverr_ff <= nxt_err;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < NSRC; i++) period_ff[i] <= PERIOD_RST;
            for (int d = 0; d < NDST; d++) sel_ff[d] <= SEL_RST;
            ratio_ff[0] <= RATIO_RST;
            ratio_ff[1] <= RATIO_RST;
            ctrl_ff     <= CTRL_RST;
            trim_ff     <= TRIM_RST;
        end else if (wr_en && !pslverr_ff) begin
            if (idx == IDX_RATIO0) ratio_ff[0] <= pwdata[15:0];
            if (idx == IDX_RATIO1) ratio_ff[1] <= pwdata[15:0];
            if (idx >= IDX_PERIOD && idx < IDX_PERIOD + 14'(NSRC))
                period_ff[4'(idx - IDX_PERIOD)] <= pwdata;
            if (idx >= IDX_SEL && idx < IDX_SEL + 14'(NDST))
                sel_ff[3'(idx - IDX_SEL)] <= pwdata[4:0];
            if (idx == IDX_CTRL) ctrl_ff <= pwdata[2:0];
            if (idx == IDX_TRIM) trim_ff <= pwdata[7:0];
        end
    end

    // a software write wins over the self-clear in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            shift_ff[0] <= SHIFT_RST;
            shift_ff[1] <= SHIFT_RST;
        end else begin
            for (int j = 0; j < 2; j++) begin
                if (wr_en && !pslverr_ff &&
                    idx == (j == 0 ? IDX_SHIFT0 : IDX_SHIFT1))
                    shift_ff[j] <= pwdata[15:0];
                else if (shift_apply[j])
                    shift_ff[j] <= SHIFT_RST;
            end
        end
    end

    // ---------------- time base ----------------
    assign tb_step = ctrl_ff[CTRL_COMP_EN] ?
                     TB_STEP + {{24{trim_ff[7]}}, trim_ff} : TB_STEP;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) tb_ff <= '0;
        else          tb_ff <= tb_ff + tb_step;
    end

    // ---------------- pin synchronisers ----------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_ff <= '0;
            s2_ff <= '0;
            s3_ff <= '0;
        end else begin
            s1_ff <= {mod_sync_pin, demod_sync_pin, conv_clk_pin};
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
        end
    end
    assign rise = s2_ff & ~s3_ff;

    // sync event tags the next stamp of that converter; set beats clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tag_pend_ff <= '0;
        end else begin
            for (int i = 0; i < NTAG_SRC; i++) begin
                if (rise[NCONV + i])
                    tag_pend_ff[i] <= 1'b1;
                else if (rise[i])
                    tag_pend_ff[i] <= 1'b0;
            end
        end
    end

    // ---------------- converters ----------------
    genvar g;
    generate
        for (g = 0; g < NCONV; g++) begin : g_conv
            logic [TS_W-1:0] last_ff;
            logic            seen_ff;
            logic [TS_W-1:0] delta;
            logic            off_period;
            logic            tag_now;
            // only reference and feedback converters have sync inputs
            if (g < NTAG_SRC) begin : g_tag
                assign tag_now = tag_pend_ff[g] || rise[NCONV + g];
            end else begin : g_notag
                assign tag_now = 1'b0;
            end
            assign delta = tb_ff - last_ff;
            // the ping pong converter has no period to check against
            assign off_period = (g != SRC_PINGPONG) &&
                (!seen_ff || delta > {period_ff[g][TS_W-2:0], 1'b0} ||
                 delta < {1'b0, period_ff[g][TS_W-1:1]});
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    last_ff         <= '0;
                    seen_ff         <= 1'b0;
                    src_valid_ff[g] <= 1'b0;
                    src_tag_ff[g]   <= 1'b0;
                    src_low_ff[g]   <= 1'b0;
                    src_stamp_ff[g] <= '0;
                end else begin
                    src_valid_ff[g] <= rise[g];
                    if (rise[g]) begin
                        last_ff         <= tb_ff;
                        seen_ff         <= 1'b1;
                        src_stamp_ff[g] <= tb_ff;
                        src_low_ff[g]   <= off_period;
                        src_tag_ff[g]   <= tag_now;
                    end
                end
            end
        end

        // ---------------- auxiliary oscillators ----------------
        for (g = 0; g < 2; g++) begin : g_osc
            localparam int S = SRC_OSC0 + g;
            logic [TS_W-1:0] acc_ff;
            logic [15:0]     cnt_ff;
            logic            roll;
            logic signed [17:0] shifted;
            logic [15:0]     nxt_cnt;
            assign roll = period_ff[S] != '0 && acc_ff + tb_step >= period_ff[S];
            assign shift_apply[g] = shift_ff[g] != '0 && !roll;
            always_comb begin
                shifted = $signed({2'b00, cnt_ff}) -
                          $signed({{2{shift_ff[g][15]}}, shift_ff[g]});
                if (shifted < 0)
                    shifted = shifted + $signed({2'b00, ratio_ff[g]}) + 18'sd1;
                else if (shifted > $signed({2'b00, ratio_ff[g]}))
                    shifted = shifted - $signed({2'b00, ratio_ff[g]}) - 18'sd1;
                nxt_cnt = shifted[15:0];
            end
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    acc_ff          <= '0;
                    cnt_ff          <= '0;
                    src_valid_ff[S] <= 1'b0;
                    src_tag_ff[S]   <= 1'b0;
                    src_low_ff[S]   <= 1'b0;
                    src_stamp_ff[S] <= '0;
                end else begin
                    src_valid_ff[S] <= roll;
                    if (roll) begin
                        acc_ff <= acc_ff + tb_step - period_ff[S];
                        src_stamp_ff[S] <= src_stamp_ff[S] + period_ff[S];
                        if (ratio_ff[g] == '0) begin
                            src_tag_ff[S] <= 1'b0;
                            cnt_ff        <= '0;
                        end else begin
                            src_tag_ff[S] <= cnt_ff == ratio_ff[g];
                            cnt_ff <= cnt_ff == ratio_ff[g] ? 16'h0000 :
                                      cnt_ff + 16'h0001;
                        end
                    end else begin
                        acc_ff <= acc_ff + tb_step;
                        // shift lands only between rollovers
                        if (shift_apply[g] && ratio_ff[g] != '0)
                            cnt_ff <= nxt_cnt;
                    end
                end
            end
        end

        // ---------------- crosspoint ----------------
        for (g = 0; g < NCH; g++) begin : g_xp
            logic [4:0] sel;
            logic       legal, need_tag, deliver;
            if (g < NDST) begin : g_dst
                assign sel   = sel_ff[g];
                assign legal = sel < 5'(NSRC) &&
                    ROUTE_MASK[g][sel[3:0]];
            end else begin : g_fb
                assign sel   = g == CH_FB0 ? SRC_FB0 : SRC_FB1;
                assign legal = 1'b1;
            end
            assign need_tag = g == D_USER0 || g == D_USER1 ||
                (g == D_PLL0 && ctrl_ff[CTRL_PLL0_TAGS]) ||
                (g == D_PLL1 && ctrl_ff[CTRL_PLL1_TAGS]);
            assign deliver = legal && src_valid_ff[sel[3:0]] &&
                (!need_tag || src_tag_ff[sel[3:0]]);
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    link.valid[g]  <= 1'b0;
                    link.tag[g]    <= 1'b0;
                    link.lowres[g] <= 1'b0;
                    link.stamp[g]  <= '0;
                end else begin
                    link.valid[g] <= deliver;
                    if (deliver) begin
                        link.tag[g]    <= src_tag_ff[sel[3:0]];
                        link.lowres[g] <= src_low_ff[sel[3:0]];
                        link.stamp[g]  <= src_stamp_ff[sel[3:0]];
                    end
                end
            end
        end
    endgenerate
endmodule

/* File: hw/tsx_sink.sv */
`timescale 1ns/1ns
module tsx_sink
    import tsx_pkg::*;
(
    input  wire logic         pclk,
    input  wire logic         presetn,
    tsx_link_if.dst           link,
    input  wire logic [1:0]   user_ack,
    output logic [1:0]        phase_valid_ff,
    output logic [63:0]       phase_err_ff,
    output logic [31:0]       comp_period_ff,
    output logic [31:0]       skew_interval_ff,
    output logic [1:0]        user_valid_ff,
    output logic [63:0]       user_stamp_ff,
    output logic [1:0]        user_lowres_ff,
    output logic [31:0]       user_missed_ff
);
    logic [TS_W-1:0] ref_ff [2];
    logic [1:0]      have_ref_ff;
    logic [TS_W-1:0] comp_last_ff, skew_last_ff;

    // phase difference: feedback of pll p against its last reference
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ref_ff[0]      <= '0;
            ref_ff[1]      <= '0;
            have_ref_ff    <= 2'b00;
            phase_valid_ff <= 2'b00;
            phase_err_ff   <= '0;
        end else begin
            for (int p = 0; p < 2; p++) begin
                phase_valid_ff[p] <= link.valid[CH_FB0 + p] & have_ref_ff[p];
                if (link.valid[CH_FB0 + p] && have_ref_ff[p])
                    phase_err_ff[p*32 +: 32] <=
                        link.stamp[CH_FB0 + p] - ref_ff[p];
                if (link.valid[D_PLL0 + p]) begin
                    ref_ff[p]      <= link.stamp[D_PLL0 + p];
                    have_ref_ff[p] <= 1'b1;
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            comp_last_ff     <= '0;
            skew_last_ff     <= '0;
            comp_period_ff   <= '0;
            skew_interval_ff <= '0;
        end else begin
            if (link.valid[D_COMP]) begin
                comp_last_ff   <= link.stamp[D_COMP];
                comp_period_ff <= link.stamp[D_COMP] - comp_last_ff;
            end
            if (link.valid[D_SKEW]) begin
                skew_last_ff     <= link.stamp[D_SKEW];
                skew_interval_ff <= link.stamp[D_SKEW] - skew_last_ff;
            end
        end
    end

    // missed count saturates; a stamp in the ack cycle is kept, not lost
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            user_valid_ff  <= 2'b00;
            user_stamp_ff  <= '0;
            user_lowres_ff <= 2'b00;
            user_missed_ff <= '0;
        end else begin
            for (int u = 0; u < 2; u++) begin
                if (link.valid[D_USER0 + u] && link.tag[D_USER0 + u]) begin
                    user_valid_ff[u]          <= 1'b1;
                    user_stamp_ff[u*32 +: 32] <= link.stamp[D_USER0 + u];
                    user_lowres_ff[u]         <= link.lowres[D_USER0 + u];
                    if (user_valid_ff[u] && !user_ack[u] &&
                        user_missed_ff[u*16 +: 16] != 16'hffff)
                        user_missed_ff[u*16 +: 16] <=
                            user_missed_ff[u*16 +: 16] + 16'h0001;
                    else if (user_ack[u])
                        user_missed_ff[u*16 +: 16] <= 16'h0000;
                end else if (user_ack[u]) begin
                    user_valid_ff[u]           <= 1'b0;
                    user_missed_ff[u*16 +: 16] <= 16'h0000;
                end
            end
        end
    end
endmodule

/* File: testbench/tsx_checker.sv */
`timescale 1ns/1ns
module tsx_checker
    import tsx_pkg::*;
(
    input wire logic                     pclk,
    input wire logic                     presetn,
    input wire logic [NCH-1:0]           valid,
    input wire logic [NCH-1:0]           tag,
    input wire logic [NCH-1:0]           lowres,
    input wire logic [NCH-1:0][TS_W-1:0] stamp
);
    logic [1:0] seen_ff;

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // feedback channels have fixed sources, so first stamp is known
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            seen_ff <= 2'b00;
        end else begin
            seen_ff <= seen_ff | valid[7:6];
        end
    end

    AST_FB0_PULSE: assert property (valid[6] |=> !valid[6])
        else $error("feedback 0 stamp longer than one cycle");
    AST_FB1_PULSE: assert property (valid[7] |=> !valid[7])
        else $error("feedback 1 stamp longer than one cycle");
    AST_FB0_RISE: assert property ((valid[6] && seen_ff[0])
        |-> stamp[6] > $past(stamp[6]))
        else $error("feedback 0 stamp not after previous");
    AST_FB1_RISE: assert property ((valid[7] && seen_ff[1])
        |-> stamp[7] > $past(stamp[7]))
        else $error("feedback 1 stamp not after previous");
    AST_FB0_FIRST: assert property ((valid[6] && !seen_ff[0])
        |-> lowres[6])
        else $error("first feedback 0 stamp not low resolution");
    AST_FB1_FIRST: assert property ((valid[7] && !seen_ff[1])
        |-> lowres[7])
        else $error("first feedback 1 stamp not low resolution");
    AST_USER0_TAG: assert property (valid[4] |-> tag[4])
        else $error("untagged stamp reached user channel");
    AST_STAMP_HOLD: assert property ((valid == '0) |-> $stable(stamp))
        else $error("stamp changed without valid");
endmodule

/* File: testbench/tb_top.sv */
`timescale 1ns/1ns
module tb_top;
    import tsx_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, pready_ff, pslverr_ff;
    logic        err;
    logic [15:0] paddr;
    logic [31:0] pwdata, prdata_ff, rd, user_missed_ff;
    logic [8:0]  conv_clk_pin;
    logic [3:0]  demod_sync_pin;
    logic [1:0]  mod_sync_pin, user_ack, user_valid_ff;
    logic [32:0] q[$];
    int          fail_count, check_count, cnt[8], tcnt[8], a, b;
    // allowed sources per destination, bit n = source n
    logic [10:0] mask[4] = '{11'h62f, 11'h61f, 11'h0cf, 11'h7ff};
    logic [13:0] ridx[6] = '{IDX_RATIO0, IDX_SHIFT0, IDX_RATIO1,
                             IDX_SHIFT1, IDX_SEL, IDX_CTRL};
    logic [31:0] rrst[6] = '{0, 0, 0, 0, 32'h1f, 0};
    logic [31:0] rt[3] = '{32'h0, 32'h2, 32'h3};

    tsx_link_if link ();
    tsx_device tsx_device_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata_ff(prdata_ff), .pready_ff(pready_ff), .pslverr_ff(pslverr_ff),
        .conv_clk_pin(conv_clk_pin), .demod_sync_pin(demod_sync_pin),
        .mod_sync_pin(mod_sync_pin), .link(link));
    tsx_sink tsx_sink_inst (.pclk(pclk), .presetn(presetn), .link(link),
        .user_ack(user_ack), .phase_valid_ff(), .phase_err_ff(),
        .comp_period_ff(), .skew_interval_ff(),
        .user_valid_ff(user_valid_ff), .user_stamp_ff(), .user_lowres_ff(),
        .user_missed_ff(user_missed_ff));
    tsx_checker tsx_checker_inst (.pclk(pclk), .presetn(presetn),
        .valid(link.valid), .tag(link.tag), .lowres(link.lowres),
        .stamp(link.stamp));

    always #20 pclk = ~pclk;

    // counted on the falling edge so the main sequence never races it
    always @(negedge pclk) begin
        for (int c = 0; c < 8; c++) begin
            cnt[c] += int'(link.valid[c]);
            tcnt[c] += int'(link.valid[c] & link.tag[c]);
        end
        if (link.valid[3]) begin
            q.push_back({link.tag[3], link.stamp[3]});
        end
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic wr, input logic [13:0] idx,
                       input logic [31:0] wd);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready_ff !== 1'b1);
        rd = prdata_ff;
        err = pslverr_ff;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rchk(input logic [13:0] idx, input logic [31:0] exp,
                        input logic eerr);
        apb(1'b0, idx, 32'h0);
        check(rd, exp);
        check(32'(err), 32'(eerr));
    endtask

    task automatic pulse(input logic [8:0] pins);
        repeat (3) @(posedge pclk);
        conv_clk_pin <= pins;
        repeat (4) @(posedge pclk);
        conv_clk_pin <= 9'h0;
        repeat (30) @(posedge pclk);
    endtask

    // tag gaps must all be n+1 except the shifted one, which adds k
    task automatic scan(input int n, input int k);
        int last, sum, odd, ntag;
        last = -1;
        sum = 0;
        odd = 0;
        ntag = 0;
        for (int i = 0; i < q.size(); i++) begin
            if (i > 0) check(q[i][31:0] - q[i-1][31:0], 32'h800);
            if (q[i][32] && last >= 0 && i - last != n + 1) begin
                odd++;
                sum += i - last - n - 1;
            end
            if (q[i][32]) begin
                last = i;
                ntag++;
            end
        end
        check(32'(ntag > 1), 32'(n != 0));
        check(32'(sum), 32'(k));
        check(32'(odd), 32'(k != 0));
    endtask

    task automatic results;
        $display("checks=%0d mismatches=%0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    initial begin
        repeat (8000) @(posedge pclk);
        fail_count++;
        results();
    end

    initial begin
        {pclk, presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        {conv_clk_pin, demod_sync_pin, mod_sync_pin, user_ack} = '0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 6; i++) rchk(ridx[i], rrst[i], 1'b0);
        rchk(IDX_PERIOD + 14'd8, 32'h0, 1'b1);
        apb(1'b1, IDX_RATIO0, 32'hffff_ffff);
        rchk(IDX_RATIO0, 32'h0000_ffff, 1'b0);
        $display("registers done");
        apb(1'b1, IDX_PERIOD + 14'd9, 32'h800);
        apb(1'b1, IDX_PERIOD + 14'd10, 32'h800);
        for (int d = 0; d < 4; d++) begin
            for (int s = 0; s < 12; s++) begin
                apb(1'b1, IDX_SEL + 14'(d), 32'(s));
                a = cnt[d];
                pulse(s < 9 ? 9'(1) << s : 9'h0);
                check(32'(cnt[d] != a), 32'(s < 11 && mask[d][s]));
            end
        end
        $display("routing done");
        apb(1'b1, IDX_CTRL, 32'h2);
        apb(1'b1, IDX_SEL, 32'h0);
        a = cnt[0];
        pulse(9'h001);
        check(32'(cnt[0] - a), 32'h0);
        demod_sync_pin <= 4'h1;
        mod_sync_pin <= 2'h2;
        a = tcnt[0];
        b = tcnt[7];
        pulse(9'h021);
        check(32'(tcnt[0] - a), 32'h1);
        check(32'(tcnt[7] - b), 32'h1);
        demod_sync_pin <= 4'h0;
        mod_sync_pin <= 2'h0;
        apb(1'b1, IDX_CTRL, 32'h0);
        $display("sync tags done");
        apb(1'b1, IDX_SEL + 14'd3, 32'h9);
        apb(1'b1, IDX_SEL + 14'd4, 32'h9);
        for (int i = 0; i < 3; i++) begin
            apb(1'b1, IDX_RATIO0, rt[i]);
            repeat (40) @(posedge pclk);
            q = {};
            a = cnt[4];
            repeat (40) @(posedge pclk);
            if (i == 2) begin
                // no pll uses the oscillator here, so shifting is allowed
                apb(1'b1, IDX_SHIFT0, 32'h0000_ffff);
                // a rollover may defer the self-clear by one cycle
                @(posedge pclk);
                rchk(IDX_SHIFT0, 32'h0, 1'b0);
            end
            repeat (100) @(posedge pclk);
            scan(int'(rt[i]), i == 2 ? -1 : 0);
            check(32'(cnt[4] != a), 32'(i != 0));
        end
        check(32'(user_valid_ff[0]), 32'h1);
        apb(1'b1, IDX_RATIO0, 32'h0);
        repeat (20) @(posedge pclk);
        user_ack <= 2'h1;
        @(posedge pclk);
        user_ack <= 2'h0;
        repeat (2) @(posedge pclk);
        check(32'(user_valid_ff[0]), 32'h0);
        check(32'(user_missed_ff[15:0]), 32'h0);
        $display("oscillator tags done");
        results();
    end
endmodule
